// *** pah_host.sv ***
// host bus model driving select, write and read strobes
`timescale 1ns/1ps
`default_nettype none
module pah_host (
  input wire logic clock,
  input wire logic [pah_pkg::RES_BITS-1:0] bus,
  input wire logic oe,
  output logic sel_n = 1'b1,
  output logic wr_n = 1'b1,
  output logic rd_n = 1'b1,
  output logic [pah_pkg::RES_BITS-1:0] data,
  output logic seen_oe
);
  import pah_pkg::*;
  // select and strobe let go together; a zero hold drops the strobe before any clock edge sees it
  task automatic start_conv(input int hold, input logic sel);
    @(posedge clock);
    #2 sel_n = ~sel;
    wr_n = 1'b0;
    repeat (hold) @(posedge clock);
    #2 wr_n = 1'b1;
    sel_n = 1'b1;
  endtask
  // result is taken while both strobes still hold
  task automatic read_cyc(input logic sel);
    @(posedge clock);
    #2 sel_n = ~sel;
    rd_n = 1'b0;
    repeat (2) @(posedge clock);
    #2 data = bus;
    seen_oe = oe;
    rd_n = 1'b1;
    sel_n = 1'b1;
  endtask
endmodule
`default_nettype wire

// *** pah_pkg.sv ***
// package of constants and types for the parallel converter handshake block
package pah_pkg;
  localparam int RES_BITS = 10;
  localparam int CLK_MHZ = 40;
  localparam int CONV_TIME_NS = 6000;
  localparam int CONV_MAX_CYC = (CONV_TIME_NS * CLK_MHZ) / 1000;
  localparam int INT_DIV = 8;
  localparam int EXT_LOSS_CYC = 64;
  localparam int CNT_W = 8;
  localparam logic [RES_BITS-1:0] RESULT_RST = 10'h000;
  localparam logic [RES_BITS-1:0] ALL_ONES = 10'h3FF;
  typedef enum logic [1:0] {PAH_TRACK, PAH_HOLD, PAH_DONE} pah_state_t;
endpackage

// *** pah_sar.sv ***
// successive-approximation sequencer, one bit decided per step pulse
`timescale 1ns/1ps
`default_nettype none
module pah_sar
  import pah_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic [RES_BITS-1:0] held_sample,
  pah_sar_if.sar link
);
  typedef struct packed {
    logic busy;
    logic done;
    logic [3:0] bit_idx;
    logic [RES_BITS-1:0] trial;
  } pah_sar_st_t;
  pah_sar_st_t st_q, st_d;
  logic [RES_BITS-1:0] probe;
  always_comb begin
    st_d = st_q;
    st_d.done = 1'b0;
    probe = st_q.trial | (10'h001 << st_q.bit_idx);
    if (link.start) begin
      st_d.busy = 1'b1;
      st_d.trial = RESULT_RST;
      st_d.bit_idx = 4'(RES_BITS - 1);
    end else if (st_q.busy && link.step) begin
      // keep the trial bit when the held sample is at or above the probe
      if (held_sample >= probe) begin
        st_d.trial = probe;
      end
      if (st_q.bit_idx == 4'h0) begin
        st_d.busy = 1'b0;
        st_d.done = 1'b1;
      end else begin
        st_d.bit_idx = st_q.bit_idx - 4'h1;
      end
    end
  end
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end
  assign link.busy = st_q.busy;
  assign link.done = st_q.done;
  assign link.result = st_q.trial;
  // rise only: a frozen clock enable may hold done while busy is already low
  done_after_busy_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(link.done) |-> $past(st_q.busy))
    else $error("done without a running conversion");
endmodule
`default_nettype wire

// *** pah_sar_if.sv ***
// interface between the handshake control and the approximation sequencer
`timescale 1ns/1ps
`default_nettype none
interface pah_sar_if;
  logic start;
  logic step;
  logic busy;
  logic done;
  logic [9:0] result;
  modport ctrl (output start, output step, input busy, input done, input result);
  modport sar (input start, input step, output busy, output done, output result);
endinterface
`default_nettype wire

// *** pah_top.sv ***
// handshake control: select, write start, done flag, result latch and bus drive
`timescale 1ns/1ps
`default_nettype none
module pah_top
  import pah_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clk_en,
  input wire logic sel_n,
  input wire logic wr_n,
  input wire logic rd_n,
  input wire logic external_clock_in,
  input wire logic [RES_BITS-1:0] analog_code,
  input wire logic over_ref_hi,
  input wire logic under_ref_lo,
  output logic [RES_BITS-1:0] result_bus,
  output logic result_bus_oe,
  output logic done_n,
  output logic tracking,
  output logic ext_clock_used
);
  import pah_pkg::*;
  typedef struct packed {
    pah_state_t state;
    logic wr_act;
    logic ext_prev;
    logic ext_seen;
    logic [CNT_W-1:0] ext_idle;
    logic [CNT_W-1:0] div_cnt;
    logic [CNT_W-1:0] conv_cnt;
    logic [3:0] steps;
    logic [RES_BITS-1:0] sample;
    logic [RES_BITS-1:0] latch;
    logic [RES_BITS-1:0] bus;
    logic oe;
    logic done_n;
    logic tracking;
  } pah_st_t;
  pah_st_t st_q, st_d;
  pah_sar_if sar_link ();
  logic ext_rise;
  logic int_tick;
  logic rd_sel;
  logic [RES_BITS-1:0] clamped;
  always_comb begin
    st_d = st_q;
    // out-of-range inputs clamp to the code ends
    if (over_ref_hi) begin
      clamped = ALL_ONES;
    end else if (under_ref_lo) begin
      clamped = RESULT_RST;
    end else begin
      clamped = analog_code;
    end
    rd_sel = !sel_n && !rd_n;
    ext_rise = external_clock_in && !st_q.ext_prev;
    // internal step every INT_DIV cycles keeps ten steps well inside the time limit
    int_tick = (st_q.div_cnt == CNT_W'(INT_DIV - 1));
    st_d.ext_prev = external_clock_in;
    st_d.div_cnt = int_tick ? '0 : CNT_W'(st_q.div_cnt + 1'b1);
    // edges on the external input mark it present until it idles
    if (ext_rise) begin
      st_d.ext_seen = 1'b1;
      st_d.ext_idle = '0;
    end else if (st_q.ext_idle == CNT_W'(EXT_LOSS_CYC)) begin
      st_d.ext_seen = 1'b0;
    end else begin
      st_d.ext_idle = CNT_W'(st_q.ext_idle + 1'b1);
    end
    sar_link.start = 1'b0;
    sar_link.step = st_q.ext_seen ? ext_rise : int_tick;
    // select may let go together with the strobe, so either rising ends the strobe
    st_d.wr_act = !sel_n && !wr_n;
    unique case (st_q.state)
      PAH_TRACK: begin
        st_d.tracking = 1'b1;
        st_d.sample = clamped;
        // conversion starts on the rising edge of a selected write
        if (st_q.wr_act && (wr_n || sel_n)) begin
          st_d.state = PAH_HOLD;
          st_d.tracking = 1'b0;
          st_d.conv_cnt = '0;
          st_d.steps = '0;
          sar_link.start = 1'b1;
        end
      end
      PAH_HOLD: begin
        st_d.conv_cnt = CNT_W'(st_q.conv_cnt + 1'b1);
        // step count lets the checks see the sequencer finish on its last step
        if (sar_link.step) begin
          st_d.steps = st_q.steps + 4'h1;
        end
        // latch the result and pull the done flag low
        if (sar_link.done) begin
          st_d.latch = sar_link.result;
          st_d.done_n = 1'b0;
          st_d.state = PAH_DONE;
        end
      end
      PAH_DONE: begin
        // a selected read raises the flag; tracking restarts on its rise
        if (rd_sel) begin
          st_d.done_n = 1'b1;
          st_d.state = PAH_TRACK;
          st_d.tracking = 1'b1;
        end
      end
    endcase
    // a write while not tracking is ignored: the hold is already in progress
    st_d.oe = rd_sel;
    st_d.bus = rd_sel ? st_q.latch : '0;
  end

  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= '0;
      st_q.done_n <= 1'b1;
      st_q.tracking <= 1'b1;
      st_q.state <= PAH_TRACK;
    end else if (clk_en) begin
      st_q <= st_d;
    end
  end

  pah_sar u_sar (
    .clock(clock),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .held_sample(st_q.sample),
    .link(sar_link.sar)
  );

  assign result_bus = st_q.bus;
  assign result_bus_oe = st_q.oe;
  assign done_n = st_q.done_n;
  assign tracking = st_q.tracking;
  assign ext_clock_used = st_q.ext_seen;

  // outputs are registered, so checks from an input to an output allow the one-cycle lag of the state
  bus_drive_sel_a: assert property (@(posedge clock) disable iff (!rst_n)
    $past(clk_en) && result_bus_oe |-> $past(!sel_n && !rd_n))
    else $error("bus driven unselected");
  bus_off_idle_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && $past(clk_en) && $past(sel_n) |-> !result_bus_oe)
    else $error("bus on with select high");
  start_hold_a: assert property (@(posedge clock) disable iff (!rst_n)
    sar_link.start && clk_en |=> !tracking)
    else $error("no hold after write");
  conv_bound_a: assert property (@(posedge clock) disable iff (!rst_n)
    st_q.state == PAH_HOLD && !st_q.ext_seen |-> st_q.conv_cnt <= CNT_W'(CONV_MAX_CYC))
    else $error("conversion too long");
  done_low_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && sar_link.done && st_q.state == PAH_HOLD |=> !done_n)
    else $error("done flag not low");
  read_raise_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && st_q.state == PAH_DONE && rd_sel |=> done_n && tracking)
    else $error("read no raise");
  track_done_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(done_n) |-> tracking)
    else $error("not tracking after done rise");
  ext_step_a: assert property (@(posedge clock) disable iff (!rst_n)
    st_q.ext_seen && sar_link.step |-> ext_rise)
    else $error("step not from external clock");

  // state and bus checks that a broken sequencer or mux would trip
  oe_on_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_sel |=> result_bus_oe)
    else $error("bus not driven on read");
  bus_zero_off_a: assert property (@(posedge clock) disable iff (!rst_n)
    !result_bus_oe |-> result_bus == '0)
    else $error("bus value while released");
  bus_latch_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && rd_sel |=> result_bus == $past(st_q.latch))
    else $error("bus not the latched result");
  track_state_a: assert property (@(posedge clock) disable iff (!rst_n)
    tracking == (st_q.state == PAH_TRACK))
    else $error("tracking flag out of step");
  unsel_no_start_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && st_q.state == PAH_TRACK && !st_q.wr_act |=> tracking)
    else $error("hold without selected write");
  start_needs_write_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(tracking) |-> $past(st_q.wr_act && (wr_n || sel_n)))
    else $error("hold without write rise");
  sample_held_a: assert property (@(posedge clock) disable iff (!rst_n)
    st_q.state != PAH_TRACK |=> $stable(st_q.sample))
    else $error("sample moved in hold");
  start_sar_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && sar_link.start |=> sar_link.busy)
    else $error("sequencer not started");
  step_count_a: assert property (@(posedge clock) disable iff (!rst_n)
    st_q.state == PAH_HOLD |-> st_q.steps <= 4'(RES_BITS))
    else $error("too many steps");
  done_steps_a: assert property (@(posedge clock) disable iff (!rst_n)
    sar_link.done && st_q.state == PAH_HOLD |-> st_q.steps == 4'(RES_BITS))
    else $error("done after wrong step count");
  done_result_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && sar_link.done && st_q.state == PAH_HOLD |=> st_q.latch == $past(sar_link.result))
    else $error("result not latched");
  done_from_sar_a: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(done_n) |-> $past(sar_link.done))
    else $error("done flag low without result");
  done_wait_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && st_q.state == PAH_DONE && !rd_sel |=> !done_n)
    else $error("done flag left before read");
  rise_needs_read_a: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(done_n) |-> $past(rd_sel))
    else $error("done flag raised without read");
  clamp_hi_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && st_q.state == PAH_TRACK && over_ref_hi |=> st_q.sample == ALL_ONES)
    else $error("high input not clamped");
  clamp_lo_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && st_q.state == PAH_TRACK && under_ref_lo && !over_ref_hi
    |=> st_q.sample == RESULT_RST) else $error("low input not clamped");
  ext_found_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && ext_rise |=> ext_clock_used)
    else $error("external clock not taken");
  ext_lost_a: assert property (@(posedge clock) disable iff (!rst_n)
    clk_en && st_q.ext_idle == CNT_W'(EXT_LOSS_CYC) && !ext_rise |=> !ext_clock_used)
    else $error("idle external clock kept");
endmodule
`default_nettype wire

// *** parallel_adc_handshake_tb.sv ***
// self-checking bench for the parallel converter handshake block
`timescale 1ns/1ps
`default_nettype none
module parallel_adc_handshake_tb;
  import pah_pkg::*;
  logic clock = 1'b0, rst_n = 1'b0, clk_en = 1'b1, ext_clk = 1'b0, ext_on = 1'b0;
  logic hi = 1'b0, lo = 1'b0, oe, done_n, tracking, ext_used, sel_n, wr_n, rd_n, seen_oe;
  logic [RES_BITS-1:0] code = 10'h000, bus, data;
  int bad_count = 0, checks = 0, seed = 13919, n;
  pah_top uut (.clock(clock), .rst_n(rst_n), .clk_en(clk_en), .sel_n(sel_n), .wr_n(wr_n),
    .rd_n(rd_n), .external_clock_in(ext_clk), .analog_code(code), .over_ref_hi(hi),
    .under_ref_lo(lo), .result_bus(bus), .result_bus_oe(oe), .done_n(done_n),
    .tracking(tracking), .ext_clock_used(ext_used));
  pah_host host (.clock(clock), .bus(bus), .oe(oe), .sel_n(sel_n), .wr_n(wr_n),
    .rd_n(rd_n), .data(data), .seen_oe(seen_oe));
  initial forever #12.5 clock = ~clock;
  // 4.2 MHz, even duty, parked low when off
  initial forever #119 ext_clk = ext_on ? ~ext_clk : 1'b0;
  task automatic check(input logic [RES_BITS-1:0] seen, input logic [RES_BITS-1:0] exp);
    checks++;
    if (seen !== exp) begin
      bad_count++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic report_and_stop();
    $display("checks=%0d bad_count=%0d", checks, bad_count);
    if (bad_count == 0 && checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  function automatic logic [RES_BITS-1:0] exp_code(input logic [RES_BITS-1:0] c,
    input logic h, input logic l);
    return h ? ALL_ONES : (l ? 10'h000 : c);
  endfunction
  task automatic convert(input logic [RES_BITS-1:0] c, input logic h, input logic l);
    int k;
    @(posedge clock);
    #2 code = c;
    hi = h;
    lo = l;
    host.start_conv(1 + ($unsigned($random(seed)) % 3), 1'b1);
    repeat (2) @(posedge clock);
    #2 check(tracking, 1'b0);
    // input moves after the sample, so a late capture shows up
    code = ~c;
    for (k = 0; k < CONV_MAX_CYC && done_n !== 1'b0; k++) begin
      @(posedge clock);
      #2;
    end
    check(k < CONV_MAX_CYC, 1'b1);
    check(oe, 1'b0);
    check(bus, 10'h000);
    host.read_cyc(1'b1);
    check(seen_oe, 1'b1);
    check(data, exp_code(c, h, l));
    check(done_n, 1'b1);
    check(tracking, 1'b1);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    #2 rst_n = 1'b1;
    for (n = 0; n < 10; n++) begin
      convert(n == 1 ? ALL_ONES : (n < 2 ? 10'h000 : RES_BITS'($random(seed))), n == 2, n == 3);
      $display("conversion %0d done", n);
    end
    host.start_conv(2, 1'b0);
    repeat (4) @(posedge clock);
    #2 check(tracking, 1'b1);
    host.read_cyc(1'b0);
    check(seen_oe, 1'b0);
    $display("unselected strobes done");
    ext_on = 1'b1;
    repeat (40) @(posedge clock);
    #2 check(ext_used, 1'b1);
    convert(RES_BITS'($random(seed)), 1'b0, 1'b0);
    ext_on = 1'b0;
    repeat (EXT_LOSS_CYC + 8) @(posedge clock);
    #2 check(ext_used, 1'b0);
    $display("external clock done");
    report_and_stop();
  end
  initial begin
    // the plan needs about 1100 cycles, so 20000 means a hang
    #(20000 * 25);
    bad_count++;
    report_and_stop();
  end
endmodule
`default_nettype wire
